// [rtl/ocg_correct.sv]
// Top of the calibration offset and gain correction stage with its register file.
`timescale 1ns/1ps
`default_nettype none
module ocg_correct (
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic [23:0]         reg_wdata_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   output var  logic [23:0]         reg_rdata_out,
   output var  logic                reg_rvalid_out,
   input  wire logic                cal_wr_in,
   input  wire logic [7:0]          cal_addr_in,
   input  wire logic [23:0]         cal_data_in,
   input  wire logic                sample_valid_in,
   input  wire logic signed [23:0]  sample_in,
   input  wire logic [1:0]          calibration_set_select_per_result_in,
   input  wire logic                self_offset_bypass_in,
   input  wire logic                unipolar_bipolar_select_in,
   input  wire logic [23:0]         self_gain_in,
   output var  logic signed [23:0]  result_out,
   output var  logic                result_valid_out
);
   import ocg_pkg::*;

   logic [23:0] system_offset_first_reg;
   logic [23:0] system_offset_second_reg;
   logic [23:0] system_gain_first_reg;
   logic [23:0] system_gain_second_reg;
   logic [23:0] self_calibration_offset_reg;
   logic [23:0] rd_next;

   ocg_dp_if dp ();

   ocg_datapath u_datapath (
      .dp (dp.core)
   );

   // Feed the chain with the live sample and the stored coefficients.
   assign dp.raw         = sample_in;
   assign dp.set_sel     = calibration_set_select_per_result_in;
   assign dp.bypass      = self_offset_bypass_in;
   assign dp.unipolar    = unipolar_bipolar_select_in;
   assign dp.self_off    = self_calibration_offset_reg;
   assign dp.self_gain   = self_gain_in;
   assign dp.off_first   = system_offset_first_reg;
   assign dp.off_second  = system_offset_second_reg;
   assign dp.gain_first  = system_gain_first_reg;
   assign dp.gain_second = system_gain_second_reg;

   // System offsets: a measured value wins over a host write in the same cycle, since
   // the calibration result is the newer knowledge of the channel.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         system_offset_first_reg  <= OCG_OFF_RST;
         system_offset_second_reg <= OCG_OFF_RST;
      end else begin
         if (cal_wr_in && cal_addr_in == OCG_SYS_OFF_FIRST) begin
            system_offset_first_reg <= cal_data_in;
         end else if (reg_wr_in && reg_addr_in == OCG_SYS_OFF_FIRST) begin
            system_offset_first_reg <= reg_wdata_in;
         end
         if (cal_wr_in && cal_addr_in == OCG_SYS_OFF_SECOND) begin
            system_offset_second_reg <= cal_data_in;
         end else if (reg_wr_in && reg_addr_in == OCG_SYS_OFF_SECOND) begin
            system_offset_second_reg <= reg_wdata_in;
         end
      end
   end

   // System gains, same priority as the offsets.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         system_gain_first_reg  <= OCG_GAIN_RST;
         system_gain_second_reg <= OCG_GAIN_RST;
      end else begin
         if (cal_wr_in && cal_addr_in == OCG_SYS_GAIN_FIRST) begin
            system_gain_first_reg <= cal_data_in;
         end else if (reg_wr_in && reg_addr_in == OCG_SYS_GAIN_FIRST) begin
            system_gain_first_reg <= reg_wdata_in;
         end
         if (cal_wr_in && cal_addr_in == OCG_SYS_GAIN_SECOND) begin
            system_gain_second_reg <= cal_data_in;
         end else if (reg_wr_in && reg_addr_in == OCG_SYS_GAIN_SECOND) begin
            system_gain_second_reg <= reg_wdata_in;
         end
      end
   end

   // Self offset, overwritten by self-calibration or by the host.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         self_calibration_offset_reg <= OCG_OFF_RST;
      end else if (cal_wr_in && cal_addr_in == OCG_SELF_OFF) begin
         self_calibration_offset_reg <= cal_data_in;
      end else if (reg_wr_in && reg_addr_in == OCG_SELF_OFF) begin
         self_calibration_offset_reg <= reg_wdata_in;
      end
   end

   // Read mux; addresses outside this block answer zero.
   always_comb begin
      case (reg_addr_in)
         OCG_SYS_OFF_FIRST:   rd_next = system_offset_first_reg;
         OCG_SYS_OFF_SECOND:  rd_next = system_offset_second_reg;
         OCG_SYS_GAIN_FIRST:  rd_next = system_gain_first_reg;
         OCG_SYS_GAIN_SECOND: rd_next = system_gain_second_reg;
         OCG_SELF_OFF:        rd_next = self_calibration_offset_reg;
         default:             rd_next = OCG_RD_NONE;
      endcase
   end

   // Read data is registered so the serial side sees a stable word for a whole cycle.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out  <= OCG_RD_NONE;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= rd_next;
         end
      end
   end

   // One register stage on the corrected result; the result holds until the next sample.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         result_out       <= OCG_OFF_RST;
         result_valid_out <= 1'b0;
      end else begin
         result_valid_out <= sample_valid_in;
         if (sample_valid_in) begin
            result_out <= dp.result;
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_host_wr_second_off;
      reg_wr_in && reg_addr_in == OCG_SYS_OFF_SECOND && !cal_wr_in;
   endsequence
   sequence s_read_second_off;
      reg_rd_in && reg_addr_in == OCG_SYS_OFF_SECOND && !reg_wr_in && !cal_wr_in;
   endsequence
   property p_readback;
      logic [23:0] v;
      (s_host_wr_second_off, v = reg_wdata_in) ##1 s_read_second_off
         |=> reg_rvalid_out && reg_rdata_out == v;
   endproperty
   a_readback: assert property (p_readback) else $error("Readback differs from write.");

   property p_sys_hold;
      !(reg_wr_in && reg_addr_in == OCG_SYS_GAIN_FIRST)
         && !(cal_wr_in && cal_addr_in == OCG_SYS_GAIN_FIRST) |=> $stable(system_gain_first_reg);
   endproperty
   a_sys_hold: assert property (p_sys_hold) else $error("System gain changed unasked.");

   property p_self_cal_over;
      cal_wr_in && cal_addr_in == OCG_SELF_OFF
         |=> self_calibration_offset_reg == $past(cal_data_in);
   endproperty
   a_self_cal_over: assert property (p_self_cal_over) else $error("Self offset not taken.");

   property p_bypass;
      self_offset_bypass_in |-> dp.st_self_off == sample_in;
   endproperty
   a_bypass: assert property (p_bypass) else $error("Bypass did not skip offset.");

   property p_second_off;
      calibration_set_select_per_result_in == OCG_SET_SECOND
         |-> dp.st_sys_off == ocg_sat(50'(dp.st_self_gain) - 50'($signed(system_offset_second_reg)));
   endproperty
   a_second_off: assert property (p_second_off) else $error("Second offset misapplied.");

   property p_no_sys;
      calibration_set_select_per_result_in[1] |-> dp.st_sys_gain == dp.st_self_gain;
   endproperty
   a_no_sys: assert property (p_no_sys) else $error("System set not disabled.");

   property p_unity_gain;
      calibration_set_select_per_result_in == OCG_SET_FIRST && system_gain_first_reg == OCG_GAIN_RST
         |-> dp.st_sys_gain == dp.st_sys_off;
   endproperty
   a_unity_gain: assert property (p_unity_gain) else $error("Unity gain changed value.");

   property p_self_gain_unity;
      self_gain_in == OCG_GAIN_RST |-> dp.st_self_gain == dp.st_self_off;
   endproperty
   a_self_gain_unity: assert property (p_self_gain_unity) else $error("Self gain wrong.");

   property p_result_timing;
      sample_valid_in |=> result_valid_out && result_out == $past(dp.result);
   endproperty
   a_result_timing: assert property (p_result_timing) else $error("Result late or wrong.");

   property p_clamp;
      unipolar_bipolar_select_in && dp.st_sys_gain[23:22] == 2'b01 |-> dp.result == OCG_POS_FS;
   endproperty
   a_clamp: assert property (p_clamp) else $error("Unipolar scale wrapped.");
endmodule // ocg_correct
`default_nettype wire

// [rtl/ocg_pkg.sv]
// Package with offsets, field layouts, reset values and helpers for the correction stage.
package ocg_pkg;
   localparam int          OCG_W             = 24;
   localparam int          OCG_ADDR_W        = 8;
   localparam int          OCG_WIDE_W        = 50;
   localparam int          OCG_FRAC_BITS     = 23;
   // Register map, at the printed addresses of the control interface.
   localparam logic [7:0]  OCG_SYS_OFF_FIRST  = 8'h13;
   localparam logic [7:0]  OCG_SYS_OFF_SECOND = 8'h14;
   localparam logic [7:0]  OCG_SYS_GAIN_FIRST = 8'h15;
   localparam logic [7:0]  OCG_SYS_GAIN_SECOND = 8'h16;
   localparam logic [7:0]  OCG_SELF_OFF       = 8'h17;
   // Reset values: zero offset and unity gain (top bit weighs one).
   localparam logic [23:0] OCG_OFF_RST        = 24'h00_0000;
   localparam logic [23:0] OCG_GAIN_RST       = 24'h80_0000;
   localparam logic [23:0] OCG_POS_FS         = 24'h7F_FFFF;
   localparam logic [23:0] OCG_NEG_FS         = 24'h80_0000;
   localparam logic [23:0] OCG_RD_NONE        = 24'h00_0000;
   // Calibration set select codes; any code with the top bit set disables system calibration.
   typedef enum logic [1:0] {
      OCG_SET_FIRST  = 2'b00,
      OCG_SET_SECOND = 2'b01,
      OCG_SET_NONE_A = 2'b10,
      OCG_SET_NONE_B = 2'b11
   } ocg_set_t;

   // Clamp a wide signed value to the 24-bit two's complement range.
   function automatic logic signed [23:0] ocg_sat(input logic signed [49:0] v);
      logic signed [49:0] hi;
      logic signed [49:0] lo;
      hi = 50'sh0_0000_007F_FFFF;
      lo = -50'sh0_0000_0080_0000;
      if (v > hi) begin
         ocg_sat = OCG_POS_FS;
      end else if (v < lo) begin
         ocg_sat = OCG_NEG_FS;
      end else begin
         ocg_sat = v[23:0];
      end
   endfunction

   // Multiply by an unsigned 1.23 gain and clamp the result.
   function automatic logic signed [23:0] ocg_gain(input logic signed [23:0] x,
                                                    input logic [23:0] g);
      logic signed [49:0] p;
      p = 50'(x * $signed({1'b0, g}));
      ocg_gain = ocg_sat(p >>> OCG_FRAC_BITS);
   endfunction
endpackage

// [rtl/ocg_dp_if.sv]
// Interface carrying coefficients, selects and stage values between top and datapath.
`timescale 1ns/1ps
`default_nettype none
interface ocg_dp_if;
   import ocg_pkg::*;
   logic signed [23:0] raw;
   logic [1:0]         set_sel;
   logic               bypass;
   logic               unipolar;
   logic [23:0]        self_off;
   logic [23:0]        self_gain;
   logic [23:0]        off_first;
   logic [23:0]        off_second;
   logic [23:0]        gain_first;
   logic [23:0]        gain_second;
   logic signed [23:0] st_self_off;
   logic signed [23:0] st_self_gain;
   logic signed [23:0] st_sys_off;
   logic signed [23:0] st_sys_gain;
   logic signed [23:0] result;
   modport ctl  (output raw, set_sel, bypass, unipolar, self_off, self_gain, off_first,
                 off_second, gain_first, gain_second,
                 input st_self_off, st_self_gain, st_sys_off, st_sys_gain, result);
   modport core (input raw, set_sel, bypass, unipolar, self_off, self_gain, off_first,
                 off_second, gain_first, gain_second,
                 output st_self_off, st_self_gain, st_sys_off, st_sys_gain, result);
endinterface
`default_nettype wire

// [rtl/ocg_datapath.sv]
// Combinational correction chain: self offset, self gain, system offset, system gain, scale.
`timescale 1ns/1ps
`default_nettype none
module ocg_datapath (
   ocg_dp_if.core dp
);
   import ocg_pkg::*;
   logic signed [23:0] sys_off;
   logic [23:0]        sys_gain;

   // Self offset is skipped while the bypass bit is set; offsets are always signed.
   always_comb begin
      dp.st_self_off = dp.bypass ? dp.raw
                     : ocg_sat(50'(dp.raw) - 50'($signed(dp.self_off)));
   end

   // Self gain multiplies the self-offset-corrected value.
   always_comb begin
      dp.st_self_gain = ocg_gain(dp.st_self_off, dp.self_gain);
   end

   // Pick the system set for this result; the disable codes skip both system steps.
   always_comb begin
      case (ocg_set_t'(dp.set_sel))
         OCG_SET_FIRST: begin
            sys_off  = $signed(dp.off_first);
            sys_gain = dp.gain_first;
         end
         OCG_SET_SECOND: begin
            sys_off  = $signed(dp.off_second);
            sys_gain = dp.gain_second;
         end
         default: begin
            sys_off  = $signed(OCG_OFF_RST);
            sys_gain = OCG_GAIN_RST;
         end
      endcase
   end

   // System offset after self correction, then system gain, then bipolar or unipolar scale.
   always_comb begin
      dp.st_sys_off  = dp.set_sel[1] ? dp.st_self_gain
                     : ocg_sat(50'(dp.st_self_gain) - 50'(sys_off));
      dp.st_sys_gain = dp.set_sel[1] ? dp.st_sys_off
                     : ocg_gain(dp.st_sys_off, sys_gain);
      dp.result      = dp.unipolar ? ocg_sat(50'(dp.st_sys_gain) <<< 1)
                     : dp.st_sys_gain;
   end
endmodule // ocg_datapath
`default_nettype wire

// [sim/ocg_cal_model.sv]
// Behavioural model of the on-demand calibration engine that overwrites coefficients.
`timescale 1ns/1ps
`default_nettype none
module ocg_cal_model (
   input  wire logic        clk_in,
   input  wire logic        go_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [23:0] data_in,
   output var  logic        cal_wr_out,
   output var  logic [7:0]  cal_addr_out,
   output var  logic [23:0] cal_data_out
);
   // Start idle so the strobe is never unknown while the block leaves reset.
   initial begin
      cal_wr_out   = 1'b0;
      cal_addr_out = 8'h00;
      cal_data_out = 24'h00_0000;
   end
   // A measurement lands one cycle after the request; between strobes the data lines
   // toggle so that a design sampling a stale word cannot pass by luck.
   always @(posedge clk_in) begin
      cal_wr_out   <= go_in;
      cal_addr_out <= go_in ? addr_in : cal_addr_out;
      cal_data_out <= go_in ? data_in : ~cal_data_out;
   end
endmodule // ocg_cal_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking testbench for the offset and gain correction stage.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
   import ocg_pkg::*;
   typedef struct packed {
      logic [23:0] x;
      logic [1:0]  s;
      logic        b;
      logic        u;
      logic [23:0] g;
      logic [23:0] e;
   } ocg_row_t;
   logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, go_addr = 8'h00, cal_addr_in;
   logic [23:0] reg_wdata_in = 24'h00_0000, go_data = 24'h00_0000, cal_data_in;
   logic [23:0] reg_rdata_out, self_gain_in = 24'h80_0000, result_out;
   logic go = 1'b0, cal_wr_in, sample_valid_in = 1'b0, reg_rvalid_out, result_valid_out;
   logic [23:0] sample_in = 24'h00_0000;
   logic [1:0] calibration_set_select_per_result_in = 2'b00;
   logic self_offset_bypass_in = 1'b0, unipolar_bipolar_select_in = 1'b0;
   logic [23:0] cf [5];
   logic [23:0] ea, eb;
   int n_fail = 0, check_count = 0, cycles = 0;
   // Mixed rows: every select code, bypass, both scales, clamping at both ends.
   // The last field is the result that the coefficients written before the loop give.
   ocg_row_t rows [6] = '{
      '{24'h00_1000, 2'b00, 1'b0, 1'b0, 24'h80_0000, 24'h00_0778},
      '{24'h00_1000, 2'b01, 1'b0, 1'b0, 24'h80_0000, 24'h00_1968},
      '{24'h00_1000, 2'b10, 1'b0, 1'b1, 24'h80_0000, 24'h00_1FE0},
      '{24'h00_1000, 2'b11, 1'b1, 1'b0, 24'h40_0000, 24'h00_0800},
      '{24'h7F_FF00, 2'b01, 1'b1, 1'b1, 24'hFF_FFFF, 24'h7F_FFFF},
      '{24'h80_0000, 2'b00, 1'b0, 1'b0, 24'h80_0000, 24'hC0_0000}};
   logic [23:0] wv [5] = '{24'h00_0100, 24'hFF_FF00, 24'h40_0000, 24'hC0_0000, 24'h00_0010};
   always #2.5 clk_in = ~clk_in;
   ocg_correct i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .cal_wr_in(cal_wr_in),
      .cal_addr_in(cal_addr_in), .cal_data_in(cal_data_in),
      .sample_valid_in(sample_valid_in), .sample_in(sample_in),
      .calibration_set_select_per_result_in(calibration_set_select_per_result_in),
      .self_offset_bypass_in(self_offset_bypass_in),
      .unipolar_bipolar_select_in(unipolar_bipolar_select_in), .self_gain_in(self_gain_in),
      .result_out(result_out), .result_valid_out(result_valid_out));
   ocg_cal_model i_cal (.clk_in(clk_in), .go_in(go), .addr_in(go_addr), .data_in(go_data),
      .cal_wr_out(cal_wr_in), .cal_addr_out(cal_addr_in), .cal_data_out(cal_data_in));
   // Clamp to the 24-bit two's complement range instead of wrapping.
   function automatic longint sat(input longint v);
      return (v > 8388607) ? 8388607 : ((v < -8388608) ? -8388608 : v);
   endfunction
   // Reference chain built on wide integers, independent of the design's helpers.
   function automatic logic [23:0] ref_res(input ocg_row_t r);
      longint v;
      v = longint'($signed(r.x));
      if (!r.b) v = sat(v - longint'($signed(cf[4])));
      v = sat((v * longint'(r.g)) >>> 23);
      if (!r.s[1]) begin
         v = sat(v - longint'($signed(r.s[0] ? cf[1] : cf[0])));
         v = sat((v * longint'(r.s[0] ? cf[3] : cf[2])) >>> 23);
      end
      if (r.u) v = sat(2 * v);
      return v[23:0];
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Writes shadow the register file so later expectations follow the stored values.
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      if (a >= 8'h13 && a <= 8'h17) cf[a - 8'h13] = d;
   endtask
   task automatic rd(input logic [7:0] a, input logic [23:0] e);
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      `CHK(reg_rvalid_out, 1'b1)
      `CHK(reg_rdata_out, e)
   endtask
   task automatic drv(input ocg_row_t r);
      sample_valid_in <= 1'b1;
      sample_in <= r.x;
      calibration_set_select_per_result_in <= r.s;
      self_offset_bypass_in <= r.b;
      unipolar_bipolar_select_in <= r.u;
      self_gain_in <= r.g;
   endtask
   task automatic smp(input ocg_row_t r, input logic [23:0] e);
      @(posedge clk_in);
      drv(r);
      @(posedge clk_in);
      sample_valid_in <= 1'b0;
      #1;
      `CHK(result_valid_out, 1'b1)
      `CHK(result_out, e)
   endtask
   task automatic cal(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk_in);
      go <= 1'b1;
      go_addr <= a;
      go_data <= d;
      @(posedge clk_in);
      go <= 1'b0;
   endtask
   // A hang is cut short well above the roughly 90 cycles the sequence needs.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      cf = '{OCG_OFF_RST, OCG_OFF_RST, OCG_GAIN_RST, OCG_GAIN_RST, OCG_OFF_RST};
      repeat (8) @(posedge clk_in);
      `CHK(result_valid_out, 1'b0)
      `CHK(reg_rvalid_out, 1'b0)
      `CHK(reg_rdata_out, 24'h00_0000)
      `CHK(result_out, 24'h00_0000)
      rst_n_in <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'h13 + 8'(i), cf[i]);
      for (int i = 0; i < 5; i++) wr(8'h13 + 8'(i), wv[i]);
      for (int i = 0; i < 5; i++) rd(8'h13 + 8'(i), wv[i]);
      wr(8'h20, 24'h12_3456);
      rd(8'h20, OCG_RD_NONE);
      for (int i = 0; i < 6; i++) smp(rows[i], rows[i].e);
      // Gain extremes: zero and the largest multiplier just under two.
      wr(8'h15, 24'h00_0000);
      smp(rows[0], 24'h00_0000);
      wr(8'h15, 24'hFF_FFFF);
      smp(rows[0], 24'h00_1DDF);
      cal(8'h17, 24'hFF_FFF0);
      cf[4] = 24'hFF_FFF0;
      rd(8'h17, cf[4]);
      smp(rows[2], 24'h00_2020);
      // A system calibration also overwrites a gain register.
      cal(8'h16, 24'hA0_0000);
      cf[3] = 24'hA0_0000;
      rd(8'h16, cf[3]);
      // Calibration and host write to one address in one cycle: calibration wins.
      @(posedge clk_in);
      go <= 1'b1;
      go_addr <= 8'h14;
      go_data <= 24'h00_0AAA;
      @(posedge clk_in);
      go <= 1'b0;
      reg_wr_in <= 1'b1;
      reg_addr_in <= 8'h14;
      reg_wdata_in <= 24'h55_5555;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      cf[1] = 24'h00_0AAA;
      rd(8'h14, cf[1]);
      // Back-to-back samples, both on the second set.
      ea = ref_res(rows[1]);
      eb = ref_res(rows[4]);
      @(posedge clk_in);
      drv(rows[1]);
      @(posedge clk_in);
      drv(rows[4]);
      #1;
      `CHK(result_out, ea)
      @(posedge clk_in);
      sample_valid_in <= 1'b0;
      #1;
      `CHK(result_out, eb)
      // Write then read in the next cycle, then a write and a read that share a cycle:
      // the shared read must still return the old word.
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= 8'h14;
      reg_wdata_in <= 24'h12_0034;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_wdata_in <= 24'hF0_0F00;
      #1;
      `CHK(reg_rdata_out, 24'h12_0034)
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      #1;
      `CHK(reg_rvalid_out, 1'b1)
      `CHK(reg_rdata_out, 24'h12_0034)
      cf[1] = 24'hF0_0F00;
      rd(8'h14, cf[1]);
      // Reset in mid-run clears the outputs and restores the coefficients.
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      #1;
      `CHK(result_out, 24'h00_0000)
      `CHK(reg_rdata_out, 24'h00_0000)
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(8'h16, OCG_GAIN_RST);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
